// ---- src/ccr_command_control.sv ----
`timescale 1ns/1ps

module ccr_command_control (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Analogue and power controls
    output logic receiver_shutdown_o,
    output logic soft_sleep_o,
    // Interrupt
    output logic irq_o
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // True for codes the sequencer can run
    function automatic logic is_supported(input logic [3:0] code);
        is_supported = (code == ccr_pkg::CMD_MEM) || (code == ccr_pkg::CMD_TRANSMIT) ||
                       (code == ccr_pkg::CMD_SOFT_RESTART);
    endfunction : is_supported

    // Register index from a byte address, or all ones if not aligned or if either of address bits 11:10 is set
    function automatic logic [7:0] reg_index(input logic [11:0] addr);
        reg_index = (addr[1:0] == 2'b00 && addr[11:10] == 2'b00) ? addr[9:2] : 8'hff;
    endfunction : reg_index

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic rx_off;                   // Receiver shutdown bit
        logic sleep_req;                // Software sleep request
        ccr_pkg::ccr_power_e power;     // Power phase
        logic [7:0] wake_count;         // Wake-up cycles left
        logic [3:0] command;            // Running command code
        logic [1:0] status;             // Sticky events
        logic [1:0] mask;               // Event mask
        logic start;                    // Launch pulse to sequencer
        logic [31:0] rdata;             // Read data
        logic ready;                    // Access answer
        logic slverr;                   // Unmapped access answer
        logic irq;                      // Interrupt line
    } ccr_state_s;

    ccr_state_s state;        // Registered state
    ccr_state_s next_state;   // Next state
    ccr_pkg::ccr_seq_s seq;   // Sequencer status

    // ************************************************************
    // Command sequencer
    // ************************************************************
    ccr_sequencer u_sequencer (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .start_i(state.start),
        .seq_o(seq)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic [7:0] idx;
        logic wr;
        logic rd;
        logic [1:0] events;
        logic sleep_bit;
        idx = reg_index(paddr_i);
        wr = 1'b0;
        rd = 1'b0;
        events = 2'b00;
        sleep_bit = 1'b0;
        next_state = state;
        next_state.start = 1'b0;
        next_state.ready = 1'b0;
        next_state.slverr = 1'b0;

        // Access phase answered one cycle after it begins
        if (psel_i && penable_i && !state.ready) begin
            next_state.ready = 1'b1;
            wr = pwrite_i;
            rd = !pwrite_i;
        end

        // Sequencer finished: field back to idle
        if (seq.done && state.command != ccr_pkg::CMD_IDLE) begin
            next_state.command = ccr_pkg::CMD_IDLE;
            events[ccr_pkg::EV_IDLE] = 1'b1;
        end

        // Wake-up countdown
        unique case (state.power)
            ccr_pkg::CCR_AWAKE: begin
                // Nothing to count
            end
            ccr_pkg::CCR_SLEEP: begin
                if (!state.sleep_req) begin
                    next_state.power = ccr_pkg::CCR_WAKING;
                    next_state.wake_count = 8'(ccr_pkg::WAKE_CYCLES);
                end
            end
            ccr_pkg::CCR_WAKING: begin
                if (state.sleep_req) begin
                    next_state.power = ccr_pkg::CCR_SLEEP;
                end else if (state.wake_count <= 8'h01) begin
                    next_state.power = ccr_pkg::CCR_AWAKE;
                    next_state.wake_count = 8'h00;
                    events[ccr_pkg::EV_AWAKE] = 1'b1;
                end else begin
                    next_state.wake_count = state.wake_count - 8'h01;
                end
            end
            default: begin
                next_state.power = ccr_pkg::CCR_AWAKE;
            end
        endcase

        // Register writes
        if (wr) begin
            unique case (idx)
                ccr_pkg::IDX_RESERVED: begin
                    // No storage behind this offset
                end
                ccr_pkg::IDX_COMMAND: begin
                    next_state.rx_off = pwdata_i[ccr_pkg::RX_OFF_BIT];
                    // Restart running or being written blocks sleep
                    if (pwdata_i[ccr_pkg::SLEEP_BIT] && state.command != ccr_pkg::CMD_SOFT_RESTART &&
                        pwdata_i[3:0] != ccr_pkg::CMD_SOFT_RESTART) begin
                        next_state.sleep_req = 1'b1;
                        next_state.power = ccr_pkg::CCR_SLEEP;
                    end else begin
                        next_state.sleep_req = 1'b0;
                    end
                    if (pwdata_i[3:0] == ccr_pkg::CMD_IDLE) begin
                        // Software idle stops the command, no event
                        next_state.command = ccr_pkg::CMD_IDLE;
                    end else if (is_supported(pwdata_i[3:0])) begin
                        next_state.command = pwdata_i[3:0];
                        next_state.start = 1'b1;
                    end else begin
                        next_state.command = ccr_pkg::CMD_IDLE;
                        events[ccr_pkg::EV_IDLE] = 1'b1;
                    end
                end
                ccr_pkg::IDX_IRQ_STATUS: begin
                    next_state.status = state.status & ~pwdata_i[1:0];
                end
                ccr_pkg::IDX_IRQ_MASK: begin
                    next_state.mask = pwdata_i[1:0];
                end
                default: begin
                    next_state.slverr = 1'b1;
                end
            endcase
        end

        // Events win over a clearing write in the same cycle
        next_state.status = next_state.status | events;

        // Read data
        next_state.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (idx)
                ccr_pkg::IDX_RESERVED: begin
                    next_state.rdata = {24'h00_0000, ccr_pkg::RESERVED_RESET};
                end
                ccr_pkg::IDX_COMMAND: begin
                    sleep_bit = (state.power != ccr_pkg::CCR_AWAKE);
                    next_state.rdata = {26'h000_0000, state.rx_off, sleep_bit, 4'h0};
                    next_state.rdata[3:0] = state.command;
                end
                ccr_pkg::IDX_IRQ_STATUS: begin
                    next_state.rdata = {30'h0000_0000, state.status};
                end
                ccr_pkg::IDX_IRQ_MASK: begin
                    next_state.rdata = {30'h0000_0000, state.mask};
                end
                default: begin
                    next_state.slverr = 1'b1;
                end
            endcase
        end

        // Level interrupt from unmasked sticky events
        next_state.irq = |(next_state.status & next_state.mask);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state.rx_off <= ccr_pkg::COMMAND_RESET[ccr_pkg::RX_OFF_BIT];
            state.sleep_req <= ccr_pkg::COMMAND_RESET[ccr_pkg::SLEEP_BIT];
            state.power <= ccr_pkg::CCR_AWAKE;
            state.wake_count <= 8'h00;
            state.command <= ccr_pkg::COMMAND_RESET[3:0];
            state.status <= ccr_pkg::IRQ_RESET;
            state.mask <= ccr_pkg::IRQ_RESET;
            state.start <= 1'b0;
            state.rdata <= 32'h0000_0000;
            state.ready <= 1'b0;
            state.slverr <= 1'b0;
            state.irq <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Outputs, all from flip-flops
    // ************************************************************
    assign prdata_o = state.rdata;
    assign pready_o = state.ready;
    assign pslverr_o = state.slverr;
    assign receiver_shutdown_o = state.rx_off;
    assign soft_sleep_o = state.sleep_req;
    assign irq_o = state.irq;

endmodule : ccr_command_control

// ---- src/ccr_pkg.sv ----
package ccr_pkg;

    // ************************************************************
    // Register map (byte addresses = printed offsets x 4)
    // ************************************************************
    localparam logic [7:0] IDX_RESERVED = 8'h00;   // Reserved register index
    localparam logic [7:0] IDX_COMMAND = 8'h01;    // Command register index
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h02; // Sticky event status index
    localparam logic [7:0] IDX_IRQ_MASK = 8'h03;   // Event mask index

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int RX_OFF_BIT = 5;                  // Receiver shutdown bit
    localparam int SLEEP_BIT = 4;                   // Soft sleep bit
    localparam logic [7:0] RESERVED_RESET = 8'h00;  // Reserved reg reset
    localparam logic [7:0] COMMAND_RESET = 8'h20;   // Command reg reset
    localparam logic [1:0] IRQ_RESET = 2'h0;        // Status/mask reset

    // Event bits in status and mask
    localparam int EV_IDLE = 0;                     // Command finished
    localparam int EV_AWAKE = 1;                    // Wake-up completed

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [3:0] CMD_IDLE = 4'h0;         // Idle
    localparam logic [3:0] CMD_MEM = 4'h1;          // Generic short command
    localparam logic [3:0] CMD_TRANSMIT = 4'h4;     // Generic short command
    localparam logic [3:0] CMD_SOFT_RESTART = 4'hf; // Soft restart

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 5;               // 200 MHz clock
    localparam int WAKE_TIME_NS = 100;              // Wake-up duration
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXEC_TIME_NS = 50;               // Command run time
    localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        CCR_AWAKE = 2'b00,
        CCR_SLEEP = 2'b01,
        CCR_WAKING = 2'b11
    } ccr_power_e;

    // Bundle from the command sequencer
    typedef struct packed {
        logic done;          // Command finished, field back to idle
        logic busy;          // Command executing
    } ccr_seq_s;

endpackage : ccr_pkg

// ---- src/ccr_sequencer.sv ----
`timescale 1ns/1ps

// Runs a launched command for a fixed time, then reports completion
module ccr_sequencer (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Launch
    input wire logic start_i,
    // Status
    output ccr_pkg::ccr_seq_s seq_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] count;   // Cycles left
        logic busy;          // Running
        logic done;          // Finish pulse
    } ccr_seq_state_s;

    ccr_seq_state_s state;      // Registered state
    ccr_seq_state_s next_state; // Next state

    // Next-state logic
    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (start_i) begin
            // Restart timing on every launch
            next_state.busy = 1'b1;
            next_state.count = 8'(ccr_pkg::EXEC_CYCLES);
        end else if (state.busy) begin
            if (state.count <= 8'h01) begin
                next_state.busy = 1'b0;
                next_state.done = 1'b1;
                next_state.count = 8'h00;
            end else begin
                next_state.count = state.count - 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign seq_o.done = state.done;
    assign seq_o.busy = state.busy;

endmodule : ccr_sequencer

// ---- verif/ccr_chk.sv ----
`timescale 1ns/1ps
// ****************************************
// Port checker for the command register
// ****************************************
module ccr_chk (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // APB slave side
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Controls and interrupt
    input wire logic receiver_shutdown_o,
    input wire logic soft_sleep_o,
    input wire logic irq_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    logic wr_cmd; // Completing write to the command word
    logic wd5; // Written receiver shutdown bit
    logic wd4; // Written sleep bit
    assign wr_cmd = pready_o & psel_i & penable_i & pwrite_i & (paddr_i == 12'h004);
    assign wd5 = pwdata_i[5];
    assign wd4 = pwdata_i[4];

    a_reset_vals: assert property ($rose(reset_n_i) |-> receiver_shutdown_o && !soft_sleep_o && !irq_o)
        else $error("control pins wrong after reset");
    a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_idle_rdata: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data not zero outside answer");
    a_err_map: assert property (pready_o |-> pslverr_o == (paddr_i > 12'h00c || paddr_i[1:0] != 2'h0))
        else $error("error flag does not match address");
    a_rsvd_read: assert property (pready_o && !pwrite_i && paddr_i == 12'h000 |-> prdata_o == 32'h0)
        else $error("reserved word not zero");
    a_cmd_read: assert property (pready_o && !pwrite_i && paddr_i == 12'h004
        |-> prdata_o[31:6] == 26'h0 && prdata_o[5] == receiver_shutdown_o)
        else $error("command word read wrong");
    a_rx_write: assert property (wr_cmd |-> ##1 receiver_shutdown_o == $past(wd5))
        else $error("shutdown pin ignores write");
    a_rx_hold: assert property (!$stable(receiver_shutdown_o) |-> wr_cmd || $past(wr_cmd))
        else $error("shutdown pin changed without write");
    a_sleep_set: assert property (wr_cmd && wd4 && pwdata_i[3:0] == 4'h0 |-> ##1 soft_sleep_o)
        else $error("sleep not entered");
    a_sleep_block: assert property (wr_cmd && wd4 && pwdata_i[3:0] == 4'hf && !soft_sleep_o
        |-> ##1 !soft_sleep_o)
        else $error("sleep entered during restart");
    a_irq_mask: assert property (pready_o && pwrite_i && paddr_i == 12'h00c && pwdata_i[1:0] == 2'h0
        |-> ##2 !irq_o)
        else $error("interrupt high with all masked");

    c_sleep: cover property (wr_cmd && wd4);
    c_err: cover property (pready_o && pslverr_o);
    c_irq: cover property ($rose(irq_o));
endmodule : ccr_chk

bind ccr_command_control ccr_chk u_chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .receiver_shutdown_o(receiver_shutdown_o),
    .soft_sleep_o(soft_sleep_o), .irq_o(irq_o));

// ---- verif/ccr_host.sv ----
`timescale 1ns/1ps
// ****************************************
// Host model: APB master
// ****************************************
module ccr_host (
    // Clock
    input wire logic clock_i,
    // APB towards the register block
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    // Idle bus from time zero
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
    end

    // One transfer: setup, access held until ready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] q, output logic e, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge clock_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= {24'h0, d};
        @(posedge clock_i);
        penable_o <= 1'b1;
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge clock_i);
            ok = (pready_i === 1'b1);
        end
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released lines show junk, not the last value
        paddr_o <= ~a;
        pwdata_o <= ~pwdata_o;
    endtask : xfer
endmodule : ccr_host

// ---- verif/tb.sv ----
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module tb;
    typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [31:0] q; logic e; logic rx;} ccr_row_s;
    logic clock = 1'b0; // 200 MHz clock
    logic reset_n = 1'b0; // Active low reset
    logic psel, penable, pwrite, pready, pslverr, rx_off, sleep, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int mismatches = 0;
    int n_compared = 0;
    logic [7:0] codes [3] = '{8'h01, 8'h04, 8'h07}; // Two supported, one unknown
    ccr_row_s rows [8] = '{
        '{1'b0, 12'h000, 8'h00, 32'h00, 1'b0, 1'b1}, '{1'b0, 12'h004, 8'h00, 32'h20, 1'b0, 1'b1},
        '{1'b0, 12'h008, 8'h00, 32'h00, 1'b0, 1'b1}, '{1'b0, 12'h010, 8'h00, 32'h00, 1'b1, 1'b1},
        '{1'b1, 12'h006, 8'h00, 32'h00, 1'b1, 1'b1}, '{1'b1, 12'h004, 8'h00, 32'h00, 1'b0, 1'b0},
        '{1'b0, 12'h004, 8'h00, 32'h00, 1'b0, 1'b0}, '{1'b1, 12'h004, 8'h20, 32'h00, 1'b0, 1'b1}};

    always #2.5 clock = ~clock;

    ccr_command_control dut (.clock_i(clock), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .receiver_shutdown_o(rx_off), .soft_sleep_o(sleep), .irq_o(irq));
    ccr_host host (.clock_i(clock), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

    // Verdict and end of run
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // Word compare
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    // Single-bit compare
    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    // Bus transfer; a hung bus ends the run
    task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] d);
        logic ok;
        host.xfer(w, a, d, q, e, ok);
        if (!ok) begin
            mismatches++;
            final_report();
        end
    endtask : xf

    // Read until masked value matches, bounded
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        q = ~x;
        for (int i = 0; i < 20 && (q & m) !== x; i++) begin
            xf(1'b0, a, 8'h00);
        end
        cmp_word(q & m, x);
    endtask : poll

    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        cmp_word({29'h0, rx_off, sleep, irq}, 32'h4);
        foreach (rows[i]) begin
            xf(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) cmp_word(q, rows[i].q);
            cmp_bit(e, rows[i].e);
            @(negedge clock);
            cmp_bit(rx_off, rows[i].rx);
        end
        $display("test table done");
        xf(1'b1, 12'h00c, 8'h01);
        for (int k = 0; k < 3; k++) begin
            xf(1'b1, 12'h004, codes[k]);
            if (k < 2) xf(1'b0, 12'h004, 8'h00);
            if (k < 2) cmp_word(q, {24'h0, codes[k]});
            poll(12'h004, 32'h0f, 32'h0);
            xf(1'b0, 12'h008, 8'h00);
            cmp_word(q, 32'h1);
            cmp_bit(irq, 1'b1);
            xf(1'b1, 12'h008, 8'h01);
        end
        xf(1'b1, 12'h00c, 8'h00);
        xf(1'b1, 12'h004, 8'h00);
        poll(12'h008, 32'h3, 32'h0);
        xf(1'b1, 12'h004, 8'h04);
        poll(12'h008, 32'h1, 32'h1);
        cmp_bit(irq, 1'b0);
        xf(1'b1, 12'h00c, 8'h01);
        xf(1'b0, 12'h000, 8'h00);
        cmp_bit(irq, 1'b1);
        xf(1'b1, 12'h008, 8'h01);
        xf(1'b0, 12'h000, 8'h00);
        cmp_bit(irq, 1'b0);
        $display("test commands done");
        xf(1'b1, 12'h004, 8'h10);
        @(negedge clock);
        cmp_bit(sleep, 1'b1);
        xf(1'b1, 12'h004, 8'h00);
        xf(1'b0, 12'h004, 8'h00);
        cmp_word(q & 32'h10, 32'h10);
        poll(12'h004, 32'h10, 32'h0);
        xf(1'b0, 12'h008, 8'h00);
        cmp_word(q & 32'h2, 32'h2);
        xf(1'b1, 12'h008, 8'h03);
        $display("test sleep done");
        xf(1'b1, 12'h004, 8'h3f);
        @(negedge clock);
        cmp_bit(sleep, 1'b0);
        poll(12'h004, 32'h1f, 32'h0);
        $display("test restart done");
        xf(1'b1, 12'h004, 8'h01);
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        xf(1'b0, 12'h004, 8'h00);
        cmp_word(q, 32'h20);
        $display("test mid reset done");
        final_report();
    end
endmodule : tb
